// file: vssmc_pkg.sv
/*
  vssmc_pkg: shared types and constants for the set-up byte loader that
  programs the decoder's system, video, sync and serial-port configuration.
  Assumes a 40 MHz system clock and a byte-wide write path into the decoder.
*/
package vssmc_pkg;

  // clock and write-cycle timing
  localparam int VSSMC_CLK_MHZ = 40;
  localparam int VSSMC_WR_PULSE_NS = 50;
  localparam int VSSMC_WR_RECOVER_NS = 50;
  localparam int VSSMC_WR_PULSE_CYC =
    ((VSSMC_WR_PULSE_NS * VSSMC_CLK_MHZ + 999) / 1000 < 1) ? 1 :
    (VSSMC_WR_PULSE_NS * VSSMC_CLK_MHZ + 999) / 1000;
  localparam int VSSMC_WR_RECOVER_CYC =
    ((VSSMC_WR_RECOVER_NS * VSSMC_CLK_MHZ + 999) / 1000 < 1) ? 1 :
    (VSSMC_WR_RECOVER_NS * VSSMC_CLK_MHZ + 999) / 1000;
  // wait-ready cycles before the synchronised ready is trusted again
  localparam int VSSMC_READY_SETTLE_CYC = 2;

  // set-up byte numbers inside the decoder's parameter space
  localparam logic [7:0] VSSMC_NUM_SYSTEM = 8'h01;
  localparam logic [7:0] VSSMC_NUM_VIDEO = 8'h02;
  localparam logic [7:0] VSSMC_NUM_SYNC = 8'h03;
  localparam logic [7:0] VSSMC_NUM_PORT1 = 8'h04;
  localparam logic [7:0] VSSMC_NUM_PORT2 = 8'h05;
  localparam int VSSMC_NUM_BYTES = 5;

  // colour depth codes
  localparam logic [1:0] VSSMC_DEPTH_24 = 2'h0;
  localparam logic [1:0] VSSMC_DEPTH_565 = 2'h1;
  localparam logic [1:0] VSSMC_DEPTH_555 = 2'h2;
  localparam logic [1:0] VSSMC_DEPTH_RSVD = 2'h3;

  // serial port stream codes
  localparam logic [2:0] VSSMC_STREAM_AUDIO1 = 3'h0;
  localparam logic [2:0] VSSMC_STREAM_AUDIO2 = 3'h1;
  localparam logic [2:0] VSSMC_STREAM_PRIV1 = 3'h2;
  localparam logic [2:0] VSSMC_STREAM_PRIV2 = 3'h4;
  localparam logic [2:0] VSSMC_STREAM_NONE = 3'h7;

  // system configuration byte, msb first
  typedef struct packed {
    logic bitstream_type;
    logic frame_rate_ctrl;
    logic interface_mode_flag;
    logic still_image_flag;
    logic [2:0] rsvd;
    logic hold_last_picture;
  } vssmc_sys_t;

  // video output configuration byte
  typedef struct packed {
    logic output_size_select;
    logic chroma_replicate_select;
    logic color_space_select;
    logic [1:0] color_depth_field;
    logic chroma_subsample_select;
    logic chroma_bias_enable;
    logic composite_blank_select;
  } vssmc_vid_t;

  // sync signal configuration byte
  typedef struct packed {
    logic sync_direction;
    logic hsync_polarity;
    logic vsync_polarity;
    logic field_index_polarity;
    logic hsync_length_select;
    logic vsync_length_select;
    logic first_field_select;
    logic pixel_clock_select;
  } vssmc_syn_t;

  // serial port configuration byte
  typedef struct packed {
    logic [1:0] rsvd;
    logic port_frame_strobe_type;
    logic port_clock_direction;
    logic [2:0] port_stream_select;
    logic port_active;
  } vssmc_port_t;

  // user request: wanted settings plus stream kind
  typedef struct packed {
    logic video_only;
    vssmc_sys_t sys;
    vssmc_vid_t vid;
    vssmc_syn_t syn;
    vssmc_port_t sp1;
    vssmc_port_t sp2;
  } vssmc_req_t;

  // one bit per setting that had to be corrected
  typedef struct packed {
    logic reserved_bits;
    logic hold_picture;
    logic output_size;
    logic color_space;
    logic color_depth;
    logic subsample;
    logic chroma_bias;
    logic composite_blank;
    logic sync_setup;
    logic field_polarity;
    logic first_field;
    logic pixel_clock;
    logic port_setup;
    logic reserved_stream;
    logic duplicate_stream;
    logic video_only_port;
  } vssmc_fault_t;

  // corrected bytes and the faults found
  typedef struct packed {
    vssmc_fault_t fault;
    vssmc_sys_t sys;
    vssmc_vid_t vid;
    vssmc_syn_t syn;
    vssmc_port_t sp1;
    vssmc_port_t sp2;
  } vssmc_image_t;

endpackage : vssmc_pkg

// file: vssmc_loader.sv
/*
  vssmc_loader: host-side controller that takes wanted configuration
  settings, forces them into a legal combination, and writes the five
  configuration bytes into the decoder one by one.
  Assumes the decoder takes a byte on the rising edge of an active-low
  write strobe and raises a ready pin, asynchronous to clk_i, when it
  can accept the next set-up byte.
*/
`timescale 1ns/100ps

// Overview of operation
// - bit 4 still images; bits 3-1 zero
// - bit 0 holds last picture; 0 when enabled
// - size bit 1 enabled, 0 still mode
// - colour space RGB forbidden in enabled mode
// - depth 24/565/555, 11 reserved, 00 for YUV
// - 4:1:1 only interlaced YUV
// - chroma bias off for RGB output
// - blanking only with output sync, not enabled
// - enabled mode needs sync direction output
// - field polarity 0 when enabled or blanking
// - enabled mode needs long horizontal sync
// - enabled mode needs long vertical sync
// - first field select 0 for progressive
// - pixel clock 0 interlaced, 1 enabled
// - strobe, clock direction 0 when inactive
// - no shared stream code; inactive uses 111
// - video-only or unused ports inactive
module vssmc_loader
  import vssmc_pkg::*;
#(
  parameter int WR_PULSE_CYC = VSSMC_WR_PULSE_CYC,
  parameter int WR_RECOVER_CYC = VSSMC_WR_RECOVER_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // user side
  input wire logic start_i,
  input wire vssmc_req_t req_i,
  output logic busy_o,
  output logic done_o,
  output vssmc_fault_t fault_o,
  // decoder set-up write pins
  output logic [7:0] dev_addr_o,
  output logic [7:0] dev_data_o,
  output logic dev_wr_n_o,
  input wire logic dev_ready_i
);

  typedef enum {ST_IDLE, ST_WAIT_READY, ST_STROBE, ST_RECOVER} vssmc_state_t;

  // last byte position and load values of the shared timer
  localparam logic [2:0] LAST_IDX = 3'(VSSMC_NUM_BYTES - 1);
  localparam logic [3:0] PULSE_LOAD = 4'(WR_PULSE_CYC - 1);
  localparam logic [3:0] RECOVER_LOAD = 4'(WR_RECOVER_CYC - 1);
  localparam logic [3:0] SETTLE_LOAD = 4'(VSSMC_READY_SETTLE_CYC - 1);

  // stream codes outside the defined set
  function automatic logic vssmc_stream_rsvd(input logic [2:0] code);
    vssmc_stream_rsvd = !(code == VSSMC_STREAM_AUDIO1 || code == VSSMC_STREAM_AUDIO2 ||
                          code == VSSMC_STREAM_PRIV1 || code == VSSMC_STREAM_PRIV2 ||
                          code == VSSMC_STREAM_NONE);
  endfunction : vssmc_stream_rsvd

  // legal form of one serial port byte
  function automatic vssmc_port_t vssmc_fix_port(input vssmc_port_t p, input logic off);
    vssmc_port_t q;
    q = p;
    q.rsvd = '0;
    if (off || vssmc_stream_rsvd(p.port_stream_select)) begin
      q.port_active = 1'b0;
    end
    if (!q.port_active) begin
      q.port_frame_strobe_type = 1'b0;
      q.port_clock_direction = 1'b0;
      q.port_stream_select = VSSMC_STREAM_NONE;
    end
    vssmc_fix_port = q;
  endfunction : vssmc_fix_port

  // force the wanted settings into a legal combination
  function automatic vssmc_image_t vssmc_sanitize(input vssmc_req_t r);
    vssmc_image_t m;
    logic en;
    m = '0;
    m.sys = r.sys;
    m.vid = r.vid;
    m.syn = r.syn;
    en = r.sys.interface_mode_flag;
    // system byte
    if (m.sys.rsvd != '0) begin
      m.fault.reserved_bits = 1'b1;
      m.sys.rsvd = '0;
    end
    if (en && m.sys.hold_last_picture) begin
      m.fault.hold_picture = 1'b1;
      m.sys.hold_last_picture = 1'b0;
    end
    // video byte; enabled mode wins over still mode
    if (en && !m.vid.output_size_select) begin
      m.fault.output_size = 1'b1;
      m.vid.output_size_select = 1'b1;
    end else if (!en && m.sys.still_image_flag && m.vid.output_size_select) begin
      m.fault.output_size = 1'b1;
      m.vid.output_size_select = 1'b0;
    end
    if (en && m.vid.color_space_select) begin
      m.fault.color_space = 1'b1;
      m.vid.color_space_select = 1'b0;
    end
    if (m.vid.color_depth_field == VSSMC_DEPTH_RSVD ||
        (!m.vid.color_space_select && m.vid.color_depth_field != VSSMC_DEPTH_24)) begin
      m.fault.color_depth = 1'b1;
      m.vid.color_depth_field = VSSMC_DEPTH_24;
    end
    if (m.vid.chroma_subsample_select &&
        (m.vid.output_size_select || m.vid.color_space_select)) begin
      m.fault.subsample = 1'b1;
      m.vid.chroma_subsample_select = 1'b0;
    end
    if (m.vid.chroma_bias_enable && m.vid.color_space_select) begin
      m.fault.chroma_bias = 1'b1;
      m.vid.chroma_bias_enable = 1'b0;
    end
    // sync byte; hsync and vsync polarity bits pass untouched
    if (en && !(m.syn.sync_direction && m.syn.hsync_length_select &&
                m.syn.vsync_length_select)) begin
      m.fault.sync_setup = 1'b1;
      m.syn.sync_direction = 1'b1;
      m.syn.hsync_length_select = 1'b1;
      m.syn.vsync_length_select = 1'b1;
    end
    if (m.vid.composite_blank_select && (!m.syn.sync_direction || en)) begin
      m.fault.composite_blank = 1'b1;
      m.vid.composite_blank_select = 1'b0;
    end
    if (m.syn.field_index_polarity && (en || m.vid.composite_blank_select)) begin
      m.fault.field_polarity = 1'b1;
      m.syn.field_index_polarity = 1'b0;
    end
    if (m.syn.first_field_select && m.vid.output_size_select) begin
      m.fault.first_field = 1'b1;
      m.syn.first_field_select = 1'b0;
    end
    if (!m.vid.output_size_select && m.syn.pixel_clock_select) begin
      m.fault.pixel_clock = 1'b1;
      m.syn.pixel_clock_select = 1'b0;
    end else if (en && !m.syn.pixel_clock_select) begin
      m.fault.pixel_clock = 1'b1;
      m.syn.pixel_clock_select = 1'b1;
    end
    // serial ports
    m.sp1 = vssmc_fix_port(r.sp1, r.video_only);
    m.sp2 = vssmc_fix_port(r.sp2, r.video_only);
    m.fault.video_only_port = r.video_only && (r.sp1.port_active || r.sp2.port_active);
    m.fault.reserved_stream = (r.sp1.port_active && vssmc_stream_rsvd(r.sp1.port_stream_select))
                           || (r.sp2.port_active && vssmc_stream_rsvd(r.sp2.port_stream_select));
    if (m.sp1.port_active && m.sp2.port_active &&
        m.sp1.port_stream_select == m.sp2.port_stream_select) begin
      m.fault.duplicate_stream = 1'b1;
      m.sp2 = vssmc_fix_port(m.sp2, 1'b1);
    end
    m.fault.port_setup = (m.sp1 != r.sp1) || (m.sp2 != r.sp2);
    vssmc_sanitize = m;
  endfunction : vssmc_sanitize

  // byte number for each position in the write order
  function automatic logic [7:0] vssmc_byte_num(input logic [2:0] idx);
    case (idx)
      3'h0: vssmc_byte_num = VSSMC_NUM_SYSTEM;
      3'h1: vssmc_byte_num = VSSMC_NUM_VIDEO;
      3'h2: vssmc_byte_num = VSSMC_NUM_SYNC;
      3'h3: vssmc_byte_num = VSSMC_NUM_PORT1;
      default: vssmc_byte_num = VSSMC_NUM_PORT2;
    endcase
  endfunction : vssmc_byte_num

  vssmc_state_t state_ff;
  vssmc_state_t nxt_state;
  vssmc_image_t image;
  logic [7:0] bytes_ff [VSSMC_NUM_BYTES];
  logic [2:0] idx_ff;
  logic [3:0] timer_ff;
  logic ready_s1_ff;
  logic ready_s2_ff;
  logic ready_s3_ff;
  logic ready_ff;
  logic done_ff;
  logic start_ok;
  logic timer_done;
  logic ready_ok;
  vssmc_fault_t fault_ff;
  logic [7:0] addr_ff;
  logic [7:0] data_ff;
  logic wr_n_ff;

  // corrected image, start accept, timer end, trusted ready
  assign image = vssmc_sanitize(req_i);
  assign start_ok = (state_ff == ST_IDLE) && start_i;
  assign timer_done = (timer_ff == '0);
  assign ready_ok = ready_ff && timer_done;

  // ready pin: three stages, change taken when the last two agree
  // the filtered level lags the pin by about four edges, so a drop caused
  // by a strobe shows here by the last cycle of the settle wait in wait-ready
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ready_s1_ff <= 1'b0;
      ready_s2_ff <= 1'b0;
      ready_s3_ff <= 1'b0;
      ready_ff <= 1'b0;
    end else begin
      ready_s1_ff <= dev_ready_i;
      ready_s2_ff <= ready_s1_ff;
      ready_s3_ff <= ready_s2_ff;
      if (ready_s2_ff == ready_s3_ff) begin
        ready_ff <= ready_s3_ff;
      end
    end
  end

  // next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start_i) begin
          nxt_state = ST_WAIT_READY;
        end
      end
      ST_WAIT_READY: begin
        // a ready level from before the last strobe is still in flight
        if (ready_ok) begin
          nxt_state = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (timer_done) begin
          nxt_state = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        if (timer_done) begin
          nxt_state = (idx_ff == LAST_IDX) ? ST_IDLE : ST_WAIT_READY;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // corrected bytes and faults captured at start
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fault_ff <= '0;
      for (int i = 0; i < VSSMC_NUM_BYTES; i++) begin
        bytes_ff[i] <= 8'h00;
      end
    end else if (start_ok) begin
      fault_ff <= image.fault;
      bytes_ff[0] <= image.sys;
      bytes_ff[1] <= image.vid;
      bytes_ff[2] <= image.syn;
      bytes_ff[3] <= image.sp1;
      bytes_ff[4] <= image.sp2;
    end
  end

  // byte position in the write order
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      idx_ff <= '0;
    end else if (start_ok) begin
      idx_ff <= '0;
    end else if (state_ff == ST_RECOVER && timer_done && idx_ff != LAST_IDX) begin
      idx_ff <= idx_ff + 3'h1;
    end
  end

  // strobe, recovery and ready-settle timer
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      timer_ff <= '0;
    end else if (state_ff == ST_WAIT_READY && ready_ok) begin
      timer_ff <= PULSE_LOAD;
    end else if (state_ff == ST_STROBE && timer_done) begin
      timer_ff <= RECOVER_LOAD;
    end else if (state_ff == ST_RECOVER && timer_done) begin
      timer_ff <= SETTLE_LOAD;
    end else if (!timer_done) begin
      timer_ff <= timer_ff - 4'h1;
    end
  end

  // decoder write pins
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      addr_ff <= 8'h00;
      data_ff <= 8'h00;
      wr_n_ff <= 1'b1;
    end else if (state_ff == ST_WAIT_READY && ready_ok) begin
      addr_ff <= vssmc_byte_num(idx_ff);
      data_ff <= bytes_ff[idx_ff];
      wr_n_ff <= 1'b0;
    end else if (state_ff == ST_STROBE && timer_done) begin
      wr_n_ff <= 1'b1;
    end
  end

  // completion pulse after the last byte
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= (state_ff == ST_RECOVER) && timer_done && (idx_ff == LAST_IDX);
    end
  end

  // outputs
  assign busy_o = (state_ff != ST_IDLE);
  assign done_o = done_ff;
  assign fault_o = fault_ff;
  assign dev_addr_o = addr_ff;
  assign dev_data_o = data_ff;
  assign dev_wr_n_o = wr_n_ff;

endmodule : vssmc_loader

// file: vssmc_loader_props.sv
/*
  vssmc_loader_props: port checks for the set-up byte loader.
  Assumes it is bound onto vssmc_loader and sees only its ports.
*/
`timescale 1ns/100ps
module vssmc_loader_props
  import vssmc_pkg::*;
#(
  parameter int WR_PULSE_CYC = 2,
  parameter int WR_RECOVER_CYC = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // user side
  input wire logic start_i,
  input wire logic busy_o,
  input wire logic done_o,
  // decoder pins
  input wire logic [7:0] dev_addr_o,
  input wire logic [7:0] dev_data_o,
  input wire logic dev_wr_n_o
);
  logic wr_ff;
  logic wr_fell;
  logic [7:0] low_ff;
  logic [7:0] high_ff;
  logic [7:0] last_ff;
  logic [7:0] sys_ff;
  logic [7:0] vid_ff;
  logic [7:0] sp1_ff;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  assign wr_fell = wr_ff & ~dev_wr_n_o;
  // strobe level and its low and high run lengths
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ff <= 1'b1;
      low_ff <= 8'h00;
      high_ff <= 8'h00;
    end else begin
      wr_ff <= dev_wr_n_o;
      low_ff <= dev_wr_n_o ? 8'h00 : low_ff + 8'h01;
      high_ff <= !dev_wr_n_o ? 8'h00 : (high_ff == 8'hFF ? high_ff : high_ff + 8'h01);
    end
  end
  // earlier bytes of the current load
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      last_ff <= VSSMC_NUM_PORT2;
      sys_ff <= 8'h00;
      vid_ff <= 8'h00;
      sp1_ff <= 8'h00;
    end else if (wr_fell) begin
      last_ff <= dev_addr_o;
      case (dev_addr_o)
        VSSMC_NUM_SYSTEM: sys_ff <= dev_data_o;
        VSSMC_NUM_VIDEO: vid_ff <= dev_data_o;
        VSSMC_NUM_PORT1: sp1_ff <= dev_data_o;
        default: last_ff <= dev_addr_o;
      endcase
    end
  end
  chk_pulse_width: assert property ($rose(dev_wr_n_o) |-> low_ff == WR_PULSE_CYC)
    else $error("write strobe low time wrong");
  chk_recover_gap: assert property (wr_fell |-> high_ff >= WR_RECOVER_CYC)
    else $error("write recovery too short");
  chk_bytes_hold: assert property (!$past(dev_wr_n_o) |->
    $stable(dev_addr_o) && $stable(dev_data_o))
    else $error("byte changed during strobe");
  chk_byte_order: assert property (wr_fell |-> dev_addr_o ==
    (last_ff == VSSMC_NUM_PORT2 ? VSSMC_NUM_SYSTEM : last_ff + 8'h01))
    else $error("set-up byte out of order");
  chk_idle_quiet: assert property (!busy_o |-> dev_wr_n_o)
    else $error("strobe while idle");
  chk_start_busy: assert property (start_i && !busy_o |=> busy_o)
    else $error("start not taken");
  chk_done_last: assert property (done_o |-> !busy_o && last_ff == VSSMC_NUM_PORT2)
    else $error("done before last byte");
  chk_sys_legal: assert property (wr_fell && dev_addr_o == VSSMC_NUM_SYSTEM |->
    dev_data_o[3:1] == 3'h0 && !(dev_data_o[5] && dev_data_o[0]))
    else $error("illegal system byte");
  chk_vid_enabled: assert property (wr_fell && dev_addr_o == VSSMC_NUM_VIDEO && sys_ff[5] |->
    dev_data_o[7] && !dev_data_o[5] && !dev_data_o[0])
    else $error("video byte illegal in enabled mode");
  chk_vid_space: assert property (wr_fell && dev_addr_o == VSSMC_NUM_VIDEO |->
    (dev_data_o[5] ? dev_data_o[4:3] != 2'h3 && dev_data_o[2:1] == 2'h0 : dev_data_o[4:3] == 2'h0))
    else $error("colour fields illegal");
  chk_sync_enabled: assert property (wr_fell && dev_addr_o == VSSMC_NUM_SYNC && sys_ff[5] |->
    dev_data_o[7] && !dev_data_o[4] && dev_data_o[3] && dev_data_o[2] && dev_data_o[0])
    else $error("sync byte illegal in enabled mode");
  chk_sync_scan: assert property (wr_fell && dev_addr_o == VSSMC_NUM_SYNC |->
    (vid_ff[7] ? !dev_data_o[1] : !dev_data_o[0]))
    else $error("sync byte wrong for scan mode");
  chk_port_idle: assert property (wr_fell && dev_addr_o[7:1] == 7'h02 && !dev_data_o[0] |->
    dev_data_o[7:1] == 7'h07)
    else $error("inactive port byte not idle");
  chk_port_dup: assert property (wr_fell && dev_addr_o == VSSMC_NUM_PORT2 && dev_data_o[0] &&
    sp1_ff[0] |-> dev_data_o[3:1] != sp1_ff[3:1])
    else $error("stream given to both ports");
  cov_load_done: cover property (done_o);
  cov_enabled_sync: cover property (wr_fell && dev_addr_o == VSSMC_NUM_SYNC && sys_ff[5]);
  cov_port_off: cover property (wr_fell && dev_addr_o == VSSMC_NUM_PORT2 && !dev_data_o[0]);
endmodule : vssmc_loader_props

bind vssmc_loader vssmc_loader_props #(
  .WR_PULSE_CYC(WR_PULSE_CYC),
  .WR_RECOVER_CYC(WR_RECOVER_CYC)
) u_props (
  .clk_i(clk_i),
  .reset_i(reset_i),
  .start_i(start_i),
  .busy_o(busy_o),
  .done_o(done_o),
  .dev_addr_o(dev_addr_o),
  .dev_data_o(dev_data_o),
  .dev_wr_n_o(dev_wr_n_o)
);

// file: vssmc_dev_model.sv
/*
  vssmc_dev_model: decoder side of the set-up write path with its five bytes.
  Assumes a byte lands on the strobe's rising edge; ready stalls per slow_i.
*/
`timescale 1ns/100ps
module vssmc_dev_model
  import vssmc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // write pins
  input wire logic [7:0] addr_i,
  input wire logic [7:0] data_i,
  input wire logic wr_n_i,
  input wire logic [3:0] slow_i,
  output logic ready_o
);
  logic wr_ff;
  logic [3:0] stall_ff;
  logic [7:0] system_config_byte_ff;
  logic [7:0] video_output_config_ff;
  logic [7:0] sync_signal_config_ff;
  logic [7:0] serial_port_one_config_ff;
  logic [7:0] serial_port_two_config_ff;
  int wr_count;
  int early_wr;
  assign ready_o = (stall_ff == 4'h0);
  // ready low after reset and for slow_i cycles after each write starts
  // a strobe that falls while ready is low is counted as a violation
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ff <= 1'b1;
      stall_ff <= 4'hF;
      early_wr <= 0;
    end else begin
      wr_ff <= wr_n_i;
      stall_ff <= (wr_ff && !wr_n_i) ? slow_i : (ready_o ? 4'h0 : stall_ff - 4'h1);
      if (wr_ff && !wr_n_i && !ready_o) begin
        early_wr <= early_wr + 1;
      end
    end
  end
  // store a byte on the strobe rise; defaults are all zero
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      system_config_byte_ff <= 8'h00;
      video_output_config_ff <= 8'h00;
      sync_signal_config_ff <= 8'h00;
      serial_port_one_config_ff <= 8'h00;
      serial_port_two_config_ff <= 8'h00;
      wr_count <= 0;
    end else if (!wr_ff && wr_n_i) begin
      wr_count <= wr_count + 1;
      case (addr_i)
        VSSMC_NUM_SYSTEM: system_config_byte_ff <= data_i;
        VSSMC_NUM_VIDEO: video_output_config_ff <= data_i;
        VSSMC_NUM_SYNC: sync_signal_config_ff <= data_i;
        VSSMC_NUM_PORT1: serial_port_one_config_ff <= data_i;
        VSSMC_NUM_PORT2: serial_port_two_config_ff <= data_i;
        default: wr_count <= wr_count + 1;
      endcase
    end
  end
endmodule : vssmc_dev_model

// file: vssmc_loader_tb.sv
/*
  vssmc_loader_tb: loads four set-up requests and checks the decoder bytes
  and fault flags. Assumes the checker is attached by its own bind.
*/
`timescale 1ns/100ps
module vssmc_loader_tb;
  import vssmc_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic start_i = 1'b0;
  vssmc_req_t req_i = '0;
  logic busy_o;
  logic done_o;
  vssmc_fault_t fault_o;
  logic [7:0] dev_addr_o;
  logic [7:0] dev_data_o;
  logic dev_wr_n_o;
  logic dev_ready_i;
  logic [3:0] slow_i = 4'h0;
  int errors = 0;
  int tests_run = 0;
  logic [40:0] rq [4];
  logic [55:0] ex [4];

  vssmc_loader #(.WR_PULSE_CYC(2), .WR_RECOVER_CYC(2)) uut (
    .clk_i(clk_i), .reset_i(reset_i), .start_i(start_i), .req_i(req_i),
    .busy_o(busy_o), .done_o(done_o), .fault_o(fault_o), .dev_addr_o(dev_addr_o),
    .dev_data_o(dev_data_o), .dev_wr_n_o(dev_wr_n_o), .dev_ready_i(dev_ready_i)
  );
  vssmc_dev_model dev (
    .clk_i(clk_i), .reset_i(reset_i), .addr_i(dev_addr_o), .data_i(dev_data_o),
    .wr_n_i(dev_wr_n_o), .slow_i(slow_i), .ready_o(dev_ready_i)
  );

  // 40 MHz clock
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    if (errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  // one load; poke retries start while busy, which must be ignored
  task automatic run_case(input int i, input logic [3:0] slow, input bit poke);
    int n;
    int w0;
    logic [39:0] got;
    w0 = dev.wr_count;
    @(posedge clk_i);
    slow_i <= slow;
    start_i <= 1'b1;
    req_i <= rq[i];
    @(posedge clk_i);
    start_i <= 1'b0;
    if (poke) begin
      repeat (8) @(posedge clk_i);
      start_i <= 1'b1;
      req_i <= rq[0];
      @(posedge clk_i);
      start_i <= 1'b0;
    end
    n = 0;
    while (done_o !== 1'b1 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    check(16'(n >= 3000), 16'h0000);
    got = {dev.system_config_byte_ff, dev.video_output_config_ff, dev.sync_signal_config_ff,
      dev.serial_port_one_config_ff, dev.serial_port_two_config_ff};
    check(fault_o, ex[i][55:40]);
    for (int b = 0; b < 5; b++) begin
      check({8'h00, got[8*b +: 8]}, {8'h00, ex[i][8*b +: 8]});
    end
    check(16'(dev.wr_count - w0), 16'h0005);
    check(16'(dev.early_wr), 16'h0000);
  endtask : run_case

  // main sequence
  initial begin
    rq[0] = {1'b0, 40'h01_47_C6_31_05};
    ex[0] = 56'h0000_01_47_C6_31_05;
    rq[1] = {1'b0, 40'h3F_A5_72_F0_07};
    ex[1] = 56'hD5FC_30_80_ED_0E_0E;
    rq[2] = {1'b1, 40'h90_BF_28_03_09};
    ex[2] = 56'h2F09_90_20_28_0E_0E;
    rq[3] = {1'b0, 40'h00_A8_81_19_39};
    ex[3] = 56'h000A_00_A8_81_19_0E;
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    @(negedge clk_i);
    check({8'h00, dev.sync_signal_config_ff}, 16'h0000);
    check({8'h00, dev.serial_port_one_config_ff}, 16'h0000);
    run_case(0, 4'h0, 1'b0);
    run_case(1, 4'h7, 1'b0);
    run_case(2, 4'h1, 1'b0);
    run_case(3, 4'h3, 1'b1);
    complete_run();
  end

  // watchdog against a hung load
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    complete_run();
  end
endmodule : vssmc_loader_tb
